/* shared/fcsp_pkg.sv */
// Constants, field layouts and state encoding for the filter corner serial port
package fcsp_pkg;
  // Corner code and its mapping to MHz
  localparam int          CODE_W          = 5;
  localparam logic [4:0]  CODE_RST        = 5'h00;
  localparam logic [4:0]  CORNER_MAX_CODE = 5'h1D;  // Last code that still steps
  localparam logic [4:0]  CORNER_MAX_MHZ  = 5'h1E;  // Ceiling of the corner
  localparam logic [4:0]  CORNER_STEP     = 5'h01;  // Code 0 means 1 MHz
  localparam logic [2:0]  LAST_BIT        = 3'h4;   // Five bits, counted 0..4
  localparam logic [2:0]  CNT_RST         = 3'h0;
  localparam logic [2:0]  CNT_STEP        = 3'h1;

  // Pin vector layout through the synchroniser
  localparam int          PIN_W      = 6;
  localparam int          PIN_STROBE = 0;
  localparam int          PIN_SCLK   = 1;
  localparam int          PIN_DATA   = 2;
  localparam int          PIN_GAIN   = 3;
  localparam int          PIN_CHIP   = 4;
  localparam int          PIN_OFS    = 5;
  localparam logic [5:0]  PIN_RST    = 6'h01;  // Strobe rests high

  // AXI4-Lite register map
  localparam int          ADDR_W     = 4;
  localparam logic [3:0]  REG_CODE   = 4'h0;
  localparam logic [3:0]  REG_STATUS = 4'h4;
  localparam logic [3:0]  REG_CTRL   = 4'h8;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  localparam logic [31:0] DATA_RST   = 32'h0000_0000;
  localparam int          CTRL_LOCK_BIT = 0;
  localparam int          ST_MHZ_LSB  = 8;
  localparam int          ST_GAIN_BIT = 16;
  localparam int          ST_CHIP_BIT = 17;
  localparam int          ST_OFS_BIT  = 18;
  localparam int          ST_BUSY_BIT = 19;

  // Serial transaction states, Gray along the write path
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_CMD   = 3'h1,
    ST_WR    = 3'h3,
    ST_WFULL = 3'h2,
    ST_RD    = 3'h5,
    ST_RDONE = 3'h4
  } fcsp_state_e;
endpackage : fcsp_pkg

/* rtl/fcsp_sync.sv */
// Three-stage pin synchroniser with agreement filter
module fcsp_sync #(
  parameter int               W       = 1,
  parameter logic [W-1:0]     RST_VAL = '0
) (
  input  wire logic         ref_clk_i,  // System clock
  input  wire logic         rst_i,      // Async reset, high
  input  wire logic [W-1:0] async_i,    // Pins from outside
  output logic      [W-1:0] sync_o      // Filtered levels
);
  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;
  logic [W-1:0] out_ff;

  // First stage feeds only the second, to keep metastability contained
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s1_ff <= RST_VAL;
      s2_ff <= RST_VAL;
      s3_ff <= RST_VAL;
    end
    else
    begin
      s1_ff <= async_i;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // A level counts only once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < W; gi++)
    begin : g_bit
      always_ff @(posedge ref_clk_i or posedge rst_i)
      begin
        if (rst_i)
          out_ff[gi] <= RST_VAL[gi];
        else if (s2_ff[gi] == s3_ff[gi])
          out_ff[gi] <= s3_ff[gi];
      end
    end
  endgenerate

  assign sync_o = out_ff;
endmodule : fcsp_sync

/* rtl/fcsp_top.sv */
// Filter corner serial port, static control pins and AXI4-Lite registers
module fcsp_top
  import fcsp_pkg::*;
(
  input  wire logic              ref_clk_i,             // 25 MHz system clock
  input  wire logic              rst_i,                 // Async reset, high
  // AXI4-Lite slave
  input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,        // Write address
  input  wire logic              s_axi_awvalid_i,       // Write address valid
  output logic                   s_axi_awready_o,       // Write address ready
  input  wire logic [31:0]       s_axi_wdata_i,         // Write data
  input  wire logic [3:0]        s_axi_wstrb_i,         // Write byte strobes
  input  wire logic              s_axi_wvalid_i,        // Write data valid
  output logic                   s_axi_wready_o,        // Write data ready
  output logic [1:0]             s_axi_bresp_o,         // Write response
  output logic                   s_axi_bvalid_o,        // Write response valid
  input  wire logic              s_axi_bready_i,        // Write response ready
  input  wire logic [ADDR_W-1:0] s_axi_araddr_i,        // Read address
  input  wire logic              s_axi_arvalid_i,       // Read address valid
  output logic                   s_axi_arready_o,       // Read address ready
  output logic [31:0]            s_axi_rdata_o,         // Read data
  output logic [1:0]             s_axi_rresp_o,         // Read response
  output logic                   s_axi_rvalid_o,        // Read data valid
  input  wire logic              s_axi_rready_i,        // Read data ready
  // Serial programming pins
  input  wire logic              load_strobe_n_i,       // Latch strobe, low active
  input  wire logic              serial_clk_i,          // Serial clock pin
  input  wire logic              serial_data_i,         // Serial data in
  output logic                   serial_readback_out_o, // Readback data out
  // Static control pins
  input  wire logic              front_gain_select_i,   // Low 6 dB, high 12 dB
  input  wire logic              chip_on_i,             // High enables part
  input  wire logic              offset_loop_off_i,     // High disables loop
  // Controls toward the analog path
  output logic [CODE_W-1:0]      corner_code_ch0_o,     // Channel 0 corner code
  output logic [CODE_W-1:0]      corner_code_ch1_o,     // Channel 1 corner code
  output logic [CODE_W-1:0]      corner_mhz_o,          // Corner in MHz
  output logic                   gain_12db_o,           // Both buffers at 12 dB
  output logic                   chip_enabled_o,        // Part enabled
  output logic                   offset_loop_on_o       // Offset loop running
);
  logic [PIN_W-1:0]  pin_q;
  logic              sclk_prev_ff;
  logic              strobe;
  logic              chip;
  logic              sclk_rise;
  logic              sclk_fall;
  fcsp_state_e       state_ff;
  fcsp_state_e       nxt_state;
  logic [2:0]        cnt_ff;
  logic [CODE_W-1:0] shift_ff;
  logic [CODE_W-1:0] code_ff;
  logic [CODE_W-1:0] nxt_code;
  logic [CODE_W-1:0] mhz_ff;
  logic [CODE_W-1:0] nxt_mhz;
  logic              readback_ff;
  logic              commit;
  logic              lock_ff;
  logic              gain_ff;
  logic              enab_ff;
  logic              ofs_on_ff;
  logic              aw_hold_ff;
  logic              w_hold_ff;
  logic [ADDR_W-1:0] awaddr_ff;
  logic [31:0]       wdata_ff;
  logic              wstrb0_ff;
  logic              bvalid_ff;
  logic [1:0]        bresp_ff;
  logic              rvalid_ff;
  logic [1:0]        rresp_ff;
  logic [31:0]       rdata_ff;
  logic              do_wr;
  logic              sw_code_wr;
  logic [31:0]       status_word;

  // All pins cross through the same filter so they stay aligned
  fcsp_sync #(
    .W       (PIN_W),
    .RST_VAL (PIN_RST)
  ) u_sync (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .async_i   ({offset_loop_off_i, chip_on_i, front_gain_select_i,
                 serial_data_i, serial_clk_i, load_strobe_n_i}),
    .sync_o    (pin_q)
  );

  assign strobe    = pin_q[PIN_STROBE];
  assign chip      = pin_q[PIN_CHIP];
  assign sclk_rise = pin_q[PIN_SCLK] & ~sclk_prev_ff;
  assign sclk_fall = ~pin_q[PIN_SCLK] & sclk_prev_ff;

  // Serial clock edge finder on filtered level
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      sclk_prev_ff <= 1'b0;
    else
      sclk_prev_ff <= pin_q[PIN_SCLK];
  end

  // Transaction sequencer; strobe high or chip off forces idle
  always_comb
  begin
    nxt_state = state_ff;
    if (strobe || !chip)
      nxt_state = ST_IDLE;
    else
    begin
      case (state_ff)
        ST_IDLE:  if (!lock_ff) nxt_state = ST_CMD;
        ST_CMD:   if (sclk_rise)
                    nxt_state = pin_q[PIN_DATA] ? ST_WR : ST_RD;
        ST_WR:    if (sclk_rise && cnt_ff == LAST_BIT) nxt_state = ST_WFULL;
        ST_RD:    if (sclk_fall && cnt_ff == LAST_BIT) nxt_state = ST_RDONE;
        ST_WFULL: nxt_state = ST_WFULL;
        ST_RDONE: nxt_state = ST_RDONE;
        default:  nxt_state = ST_IDLE;
      endcase
    end
  end

  // State register
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      state_ff <= ST_IDLE;
    else
      state_ff <= nxt_state;
  end

  // Bit counter, restarted by the command bit
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      cnt_ff <= CNT_RST;
    else if (state_ff == ST_CMD || strobe)
      cnt_ff <= CNT_RST;
    else if ((state_ff == ST_WR && sclk_rise) || (state_ff == ST_RD && sclk_fall))
      cnt_ff <= cnt_ff + CNT_STEP;
  end

  // Write shifter, LSB first; kept apart so a short write cannot leak
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      shift_ff <= CODE_RST;
    else if (state_ff == ST_WR && sclk_rise && !strobe && chip)
      shift_ff[cnt_ff] <= pin_q[PIN_DATA];
  end

  // Only a full five-bit write reaches the code on strobe rise
  assign commit     = (state_ff == ST_WFULL) && strobe;
  assign sw_code_wr = do_wr && (awaddr_ff == REG_CODE) && wstrb0_ff;

  // Code update; the serial port wins a same-cycle clash with software
  always_comb
  begin
    nxt_code = code_ff;
    if (commit)
      nxt_code = shift_ff;
    else if (sw_code_wr)
      nxt_code = wdata_ff[CODE_W-1:0];
    nxt_mhz = (nxt_code >= CORNER_MAX_CODE) ? CORNER_MAX_MHZ
                                            : nxt_code + CORNER_STEP;
  end

  // One shared code register for the whole part
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      code_ff <= CODE_RST;
      mhz_ff  <= CORNER_STEP;
    end
    else
    begin
      code_ff <= nxt_code;
      mhz_ff  <= nxt_mhz;
    end
  end

  // Readback driven on serial-clock falls, low outside a read
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      readback_ff <= 1'b0;
    else if (strobe || !chip)
      readback_ff <= 1'b0;
    else if (state_ff == ST_RD && sclk_fall)
      readback_ff <= code_ff[cnt_ff];
  end

  // Static pins to analog controls
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      gain_ff   <= 1'b0;
      enab_ff   <= 1'b0;
      ofs_on_ff <= 1'b0;
    end
    else
    begin
      gain_ff   <= pin_q[PIN_GAIN];
      enab_ff   <= chip;
      ofs_on_ff <= ~pin_q[PIN_OFS];
    end
  end

  // Both channels see the same register, so they can never differ
  assign corner_code_ch0_o     = code_ff;
  assign corner_code_ch1_o     = code_ff;
  assign corner_mhz_o          = mhz_ff;
  assign serial_readback_out_o = readback_ff;
  assign gain_12db_o           = gain_ff;
  assign chip_enabled_o        = enab_ff;
  assign offset_loop_on_o      = ofs_on_ff;

  // Write address and data are taken in either order, then applied together
  assign s_axi_awready_o = !aw_hold_ff && !bvalid_ff;
  assign s_axi_wready_o  = !w_hold_ff && !bvalid_ff;
  assign do_wr           = aw_hold_ff && w_hold_ff && !bvalid_ff;

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      aw_hold_ff <= 1'b0;
      w_hold_ff  <= 1'b0;
      awaddr_ff  <= REG_CODE;
      wdata_ff   <= DATA_RST;
      wstrb0_ff  <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid_i && s_axi_awready_o)
      begin
        aw_hold_ff <= 1'b1;
        awaddr_ff  <= s_axi_awaddr_i;
      end
      else if (do_wr)
        aw_hold_ff <= 1'b0;
      if (s_axi_wvalid_i && s_axi_wready_o)
      begin
        w_hold_ff <= 1'b1;
        wdata_ff  <= s_axi_wdata_i;
        wstrb0_ff <= s_axi_wstrb_i[0];
      end
      else if (do_wr)
        w_hold_ff <= 1'b0;
    end
  end

  // Control register and write response
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      lock_ff   <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff  <= RESP_OKAY;
    end
    else
    begin
      if (do_wr && awaddr_ff == REG_CTRL && wstrb0_ff)
        lock_ff <= wdata_ff[CTRL_LOCK_BIT];
      if (do_wr)
      begin
        bvalid_ff <= 1'b1;
        bresp_ff  <= (awaddr_ff == REG_CODE || awaddr_ff == REG_STATUS ||
                      awaddr_ff == REG_CTRL) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready_i)
        bvalid_ff <= 1'b0;
    end
  end

  assign s_axi_bvalid_o = bvalid_ff;
  assign s_axi_bresp_o  = bresp_ff;

  // Status word shows live pin levels and sequencer activity
  always_comb
  begin
    status_word                        = DATA_RST;
    status_word[CODE_W-1:0]            = code_ff;
    status_word[ST_MHZ_LSB +: CODE_W]  = mhz_ff;
    status_word[ST_GAIN_BIT]           = gain_ff;
    status_word[ST_CHIP_BIT]           = enab_ff;
    status_word[ST_OFS_BIT]            = ~ofs_on_ff;
    status_word[ST_BUSY_BIT]           = (state_ff != ST_IDLE);
  end

  // Read channel answers one cycle after the address is taken
  assign s_axi_arready_o = !rvalid_ff;

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= DATA_RST;
      rresp_ff  <= RESP_OKAY;
    end
    else if (s_axi_arvalid_i && s_axi_arready_o)
    begin
      rvalid_ff <= 1'b1;
      rresp_ff  <= RESP_OKAY;
      case (s_axi_araddr_i)
        REG_CODE:   rdata_ff <= {{(32-CODE_W){1'b0}}, code_ff};
        REG_STATUS: rdata_ff <= status_word;
        REG_CTRL:   rdata_ff <= {31'h0000_0000, lock_ff};
        default:
        begin
          rdata_ff <= DATA_RST;
          rresp_ff <= RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rready_i)
      rvalid_ff <= 1'b0;
  end

  assign s_axi_rvalid_o = rvalid_ff;
  assign s_axi_rdata_o  = rdata_ff;
  assign s_axi_rresp_o  = rresp_ff;

  // Checks on the serial sequencer and the analog controls
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_full_rise;
    (state_ff == ST_WFULL) && strobe;
  endsequence

  sequence s_cmd_write;
    (state_ff == ST_CMD) && sclk_rise && pin_q[PIN_DATA] && !strobe && chip;
  endsequence

  a_code_shared: assert property (corner_code_ch0_o == corner_code_ch1_o)
    else $error("channel corner codes differ");
  a_no_start_high: assert property (strobe |=> state_ff == ST_IDLE)
    else $error("transaction active with strobe high");
  a_cmd_write: assert property (s_cmd_write |=> state_ff == ST_WR)
    else $error("write command bit not decoded");
  a_first_bit: assert property ((state_ff == ST_WR && cnt_ff == CNT_RST && sclk_rise
      && !strobe && chip) |=> shift_ff[0] == $past(pin_q[PIN_DATA]))
    else $error("first write bit not in lsb");
  a_write_commit: assert property (s_full_rise |=> code_ff == $past(shift_ff))
    else $error("full write not committed");
  a_read_bit: assert property ((state_ff == ST_RD && sclk_fall && !strobe && chip)
      |=> serial_readback_out_o == $past(code_ff[cnt_ff]))
    else $error("readback bit wrong");
  a_corner_cap: assert property (code_ff >= CORNER_MAX_CODE
      |-> corner_mhz_o == CORNER_MAX_MHZ)
    else $error("corner above cap");
  a_corner_step: assert property (code_ff < CORNER_MAX_CODE
      |-> corner_mhz_o == code_ff + CORNER_STEP)
    else $error("corner step wrong");
  a_chip_off_idle: assert property (!chip |=> state_ff == ST_IDLE && !chip_enabled_o)
    else $error("disabled part still active");
  a_read_keeps: assert property (((state_ff == ST_RD || state_ff == ST_RDONE)
      && !sw_code_wr) |=> $stable(code_ff))
    else $error("read changed stored code");
  a_short_drop: assert property ((state_ff == ST_WR && strobe && !sw_code_wr)
      |=> $stable(code_ff))
    else $error("partial write changed code");
  a_loop_pin: assert property (pin_q[PIN_OFS] |=> !offset_loop_on_o)
    else $error("offset loop on while disabled");
  a_gain_pin: assert property (pin_q[PIN_GAIN] |=> gain_12db_o)
    else $error("gain select not applied");
endmodule : fcsp_top

/* bench/fcsp_host_model.sv */
// Host controller model that drives the serial programming pins
module fcsp_host_model (
  input  wire logic ref_clk_i,  // System clock, paces the link
  input  wire logic rb_i,       // Readback bit from the part
  output logic      strobe_n_o, // Latch strobe, low active
  output logic      sclk_o,     // Serial clock, still outside frames
  output logic      sdata_o     // Serial data toward the part
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle pins: strobe high, clock parked low
  initial
  begin
    strobe_n_o = 1'h1;
    sclk_o     = 1'h0;
    sdata_o    = 1'h0;
  end

  // Half of the 320 ns serial period
  task automatic half;
    repeat (4) @(posedge ref_clk_i);
  endtask : half

  // One clock pulse; data is held across the rise and only changes at the fall
  task automatic pulse(input logic b);
    sdata_o <= b;
    half();
    sclk_o <= 1'h1;
    half();
    sclk_o <= 1'h0;
  endtask : pulse

  // Opens a frame; strobe left high when a refused frame is wanted
  task automatic frame_start(input logic use_strobe);
    strobe_n_o <= !use_strobe;
    half();
  endtask : frame_start

  // Sends n bits, bit 0 first
  task automatic send_bits(input logic [7:0] v, input int n);
    for (int i = 0; i < n; i++)
    begin
      pulse(v[i]);
    end
  endtask : send_bits

  // Closes a frame; data line flips so no stale level stays readable
  task automatic frame_end;
    half();
    strobe_n_o <= 1'h1;
    sdata_o    <= ~sdata_o;
    repeat (12) @(posedge ref_clk_i);
  endtask : frame_end

  // Read command, then one bit taken just before each following fall
  task automatic read_code(output logic [4:0] c);
    pulse(1'h0);
    for (int i = 0; i < 5; i++)
    begin
      half();
      sclk_o <= 1'h1;
      half();
      c[i] = rb_i;
      sclk_o <= 1'h0;
    end
  endtask : read_code
endmodule : fcsp_host_model

/* bench/tb_top.sv */
// Self-checking bench for the filter corner serial port
module tb_top
  import fcsp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk, rst, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, rb, stb_n, sclk, sdat;
  logic        gain, chip, ofs, g12, en, loop_on;
  logic [3:0]  awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, seed, v, st;
  logic [1:0]  bresp, rresp, r;
  logic [4:0]  ch0, ch1, mhz, c, rc;
  int          n_errors, n_tests, m_code;

  fcsp_top dut (.ref_clk_i(clk), .rst_i(rst), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .load_strobe_n_i(stb_n), .serial_clk_i(sclk),
    .serial_data_i(sdat), .serial_readback_out_o(rb), .front_gain_select_i(gain),
    .chip_on_i(chip), .offset_loop_off_i(ofs), .corner_code_ch0_o(ch0),
    .corner_code_ch1_o(ch1), .corner_mhz_o(mhz), .gain_12db_o(g12),
    .chip_enabled_o(en), .offset_loop_on_o(loop_on));

  fcsp_host_model host (.ref_clk_i(clk), .rb_i(rb), .strobe_n_o(stb_n), .sclk_o(sclk),
    .sdata_o(sdat));

  // 25 MHz system clock
  initial
  begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end

  // Xorshift source, fixed start so runs repeat
  function automatic logic [31:0] rnd;
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_tests++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, seen, exp);
    end
  endtask : check

  // Model corner in MHz, saturating at the top
  function automatic int exp_mhz(input int k);
    return (k > 29) ? 30 : k + 1;
  endfunction : exp_mhz

  task automatic check_code;
    check({27'h0, ch0}, m_code, "ch0 code");
    check({27'h0, ch1}, m_code, "ch1 code");
    check({27'h0, mhz}, exp_mhz(m_code), "corner mhz");
  endtask : check_code

  // Address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] resp);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    bready  <= 1'h1;
    do
    begin
      @(posedge clk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (bvalid !== 1'h1);
    resp = bresp;
    bready <= 1'h0;
    @(posedge clk);
  endtask : axi_wr

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] resp);
    araddr  <= a;
    arvalid <= 1'h1;
    rready  <= 1'h1;
    do
    begin
      @(posedge clk);
      if (arready) arvalid <= 1'h0;
    end while (rvalid !== 1'h1);
    d = rdata;
    resp = rresp;
    rready <= 1'h0;
    @(posedge clk);
  endtask : axi_rd

  // Serial write frame: command bit, then nb bits of w
  task automatic ser_wr(input logic [6:0] w, input int nb, input logic use_strobe);
    host.frame_start(use_strobe);
    host.send_bits({w, 1'h1}, nb + 1);
    host.frame_end();
  endtask : ser_wr

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : report_and_stop

  // Watchdog sized well above the expected run
  initial
  begin
    repeat (20000) @(posedge clk);
    n_errors++;
    $display("unexpected at %0t: watchdog expired", $time);
    report_and_stop();
  end

  initial
  begin
    seed = 32'h18099C5D;
    {awvalid, wvalid, bready, arvalid, rready, gain, ofs} = 7'h00;
    {awaddr, araddr, wdata} = 40'h0;
    wstrb = 4'hF;
    chip = 1'h1;
    rst = 1'h1;
    m_code = 0;
    repeat (3) @(posedge clk);
    rst <= 1'h0;
    repeat (8) @(posedge clk);
    check_code();
    check({31'h0, rb}, 32'h0, "readback idle");
    $display("test reset done");
    // Every code through the register path, stray upper bits set
    for (int k = 0; k < 32; k++)
    begin
      axi_wr(REG_CODE, (rnd() & 32'hFFFF_FFE0) | k, r);
      m_code = k;
      repeat (2) @(posedge clk);
      check({30'h0, r}, RESP_OKAY, "code write resp");
      check_code();
    end
    axi_wr(4'hC, 32'h0000_0003, r);
    check({30'h0, r}, RESP_SLVERR, "unmapped write");
    axi_rd(4'hC, v, r);
    check({30'h0, r}, RESP_SLVERR, "unmapped read");
    axi_rd(REG_CODE, v, r);
    check(v, m_code, "code readback reg");
    // Masked low byte and the read-only status word leave the code alone
    wstrb <= 4'hE;
    axi_wr(REG_CODE, 32'h0000_0003, r);
    wstrb <= 4'hF;
    axi_wr(REG_STATUS, 32'hFFFF_FFFF, r);
    check({30'h0, r}, RESP_OKAY, "status write resp");
    check_code();
    // Port lock refuses a serial frame until software clears it
    axi_wr(REG_CTRL, 32'h0000_0001, r);
    axi_rd(REG_CTRL, v, r);
    check(v, 32'h0000_0001, "lock readback");
    ser_wr(7'h15, 5, 1'h1);
    check_code();
    axi_wr(REG_CTRL, 32'h0000_0000, r);
    $display("test register map done");
    // Serial writes; the code must wait for the strobe to rise
    for (int k = 0; k < 4; k++)
    begin
      v = rnd();
      c = v[4:0];
      host.frame_start(1'h1);
      host.send_bits({2'h0, c, 1'h1}, 6);
      repeat (8) @(posedge clk);
      check_code();
      host.frame_end();
      m_code = c;
      check_code();
      host.frame_start(1'h1);
      host.read_code(rc);
      host.frame_end();
      check({27'h0, rc}, m_code, "serial read");
      check({31'h0, rb}, 32'h0, "readback after read");
      check_code();
    end
    $display("test serial write and read done");
    ser_wr({4'h0, ~c[2:0]}, 3, 1'h1);
    check_code();
    ser_wr({2'h3, ~c}, 7, 1'h1);
    c = ~c;
    m_code = c;
    check_code();
    // Refused frames carry a code that differs from the stored one
    ser_wr({2'h0, ~c}, 5, 1'h0);
    check_code();
    $display("test refused frames done");
    // Static pins at random levels, also seen through the status word
    for (int k = 0; k < 6; k++)
    begin
      v = rnd();
      gain <= v[0];
      chip <= v[1];
      ofs  <= v[2];
      repeat (10) @(posedge clk);
      check({31'h0, g12}, v[0], "gain select");
      check({31'h0, en}, v[1], "chip enable");
      check({31'h0, loop_on}, !v[2], "offset loop");
      axi_rd(REG_STATUS, st, r);
      check(st, m_code | (exp_mhz(m_code) << 8) | (v[2:0] << 16), "status word");
    end
    chip <= 1'h0;
    repeat (10) @(posedge clk);
    ser_wr({2'h0, ~c}, 5, 1'h1);
    check_code();
    $display("test static pins done");
    report_and_stop();
  end
endmodule : tb_top
